// ==== fic_map.svh ====
`ifndef FIC_MAP_SVH
`define FIC_MAP_SVH

// geometry defaults
`define FIC_ROW_BYTES 128
`define FIC_ROWS_PER_MACRO 256
`define FIC_MACROS 2
`define FIC_USF_ROWS 4
`define FIC_CPB_OFFSET 8'h7F

// address windows
`define FIC_FLASH_BASE 32'h0000_0000
`define FIC_CTRL_BASE 32'h4000_0000

// control register offsets
`define FIC_BUF_IDX 8'h00
`define FIC_BUF_DATA 8'h04
`define FIC_ROW_CMD 8'h08
`define FIC_STATUS 8'h0C
`define FIC_CHIP_PROT 8'h10
`define FIC_GEOM 8'h14

// row command fields
`define FIC_CMD_ROW_LSB 0
`define FIC_CMD_ROW_W 16
`define FIC_CMD_KIND_LSB 16

// status fields
`define FIC_ST_BUSY 0
`define FIC_ST_REFUSED 1
`define FIC_ST_LVL_LSB 2
`define FIC_ST_DONE 4

// chip-level protection byte codes
`define FIC_CODE_LOCKED 8'h02
`define FIC_CODE_PERM 8'h04

// reset values
`define FIC_WORD_RST 32'h0000_0000

`endif

// ==== fic_pkg.sv ====
package fic_pkg;
  typedef enum logic [1:0] {
    FIC_ST_IDLE = 2'b01,
    FIC_ST_PROG = 2'b10
  } fic_state_t;

  typedef enum logic [1:0] {
    FIC_ROW_USER = 2'b00,
    FIC_ROW_SUPER = 2'b01,
    FIC_ROW_USF = 2'b10
  } fic_kind_t;

  typedef enum logic [1:0] {
    FIC_LVL_OPEN = 2'b00,
    FIC_LVL_LOCKED = 2'b01,
    FIC_LVL_PERM = 2'b10
  } fic_level_t;
endpackage

// ==== fic_guard_if.sv ====
interface fic_guard_if;
  import fic_pkg::*;
  fic_kind_t kind;
  logic row_ok;
  logic prot_bit;
  fic_level_t level;
  logic ext;
  logic allow;
  modport ctl (output kind, row_ok, prot_bit, level, ext, input allow);
  modport guard (input kind, row_ok, prot_bit, level, ext, output allow);
endinterface

// ==== fic_guard.sv ====
module fic_guard (
  fic_guard_if.guard g
);
  import fic_pkg::*;

  always_comb begin
    g.allow = g.row_ok;
    if (g.level == FIC_LVL_PERM) begin
      g.allow = 1'b0; // [RULE_05]
    end
    if (g.level == FIC_LVL_LOCKED && g.ext) begin
      g.allow = 1'b0; // [RULE_05]
    end
    if (g.kind == FIC_ROW_USER && g.prot_bit) begin
      g.allow = 1'b0; // [RULE_01]
    end
  end
endmodule

// ==== fic_flash_ctl.sv ====
// What this block does
// RULE_01: one protect bit per row blocks writes
// RULE_02: protection bytes per macro equal rows over eight
// RULE_03: programmer writes whole rows only
// RULE_04: flash read directly from address zero
// RULE_05: locked refuses external access, permanent kills debug
// RULE_06: chip protection byte at variant offset, macro 0
// RULE_07: up to four user supervisory rows, macro 0
// RULE_08: programmer maps image sections at fixed addresses
// RULE_09: programmer takes chip protection from image
// RULE_10: checksum is byte sum, low two bytes
// RULE_11: programmer compares checksums after programming
// RULE_12: protection section length is rows over eight
// RULE_13: protection data goes into supervisory rows
// RULE_14: metadata is twelve bytes, never programmed
// RULE_15: programmer checks image version equals two
// RULE_16: identity byte order hi, lo, revision, family
// RULE_17: identity match ignores revision byte
// RULE_18: programmer ignores internal and reserved fields
// RULE_19: user section length equals flash size
// RULE_20: rows and macros derived from sizes
// RULE_21: separate sticky mismatch flags per check; code rewrites each flag per check, meta_check clears sum_bad
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`include "fic_map.svh"

module fic_flash_ctl #(
  parameter int ROW_BYTES = `FIC_ROW_BYTES,
  parameter int ROWS_PER_MACRO = `FIC_ROWS_PER_MACRO,
  parameter int MACROS = `FIC_MACROS,
  parameter int USF_ROWS = `FIC_USF_ROWS,
  parameter logic [7:0] CPB_OFFSET = `FIC_CPB_OFFSET
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_ext_access,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_busy,
  output logic o_dbg_port_en,
  output fic_pkg::fic_level_t o_level
);
  import fic_pkg::*;

  localparam int WPR = ROW_BYTES / 4;
  localparam int USER_ROWS = ROWS_PER_MACRO * MACROS;
  localparam int TOT_W = (USER_ROWS + MACROS + USF_ROWS) * WPR;
  localparam int IW = $clog2(TOT_W);
  localparam int BW = $clog2(WPR);
  localparam int PROT_BYTES = ROWS_PER_MACRO / 8; // [RULE_02]
  localparam int FLASH_BYTES = USER_ROWS * ROW_BYTES;

  // nonvolatile array modelled in flip-flops: users rows, then one
  // supervisory row per macro, then user supervisory rows (macro 0)
  logic [31:0] mem_r [TOT_W];
  logic [31:0] buf_r [WPR];
  logic [BW-1:0] buf_idx_r;
  logic [BW-1:0] cnt_r;
  logic [IW-1:0] prog_base_r;
  fic_state_t state_r;
  logic refused_r;
  logic done_r;
  logic dp_wr_r;
  logic dp_ext_r;
  logic [7:0] dp_off_r;

  function automatic logic [7:0] mem_byte(input int row, input int bi);
    logic [31:0] w;
    w = mem_r[row * WPR + bi / 4];
    return w[8 * (bi % 4) +: 8];
  endfunction

  function automatic fic_level_t decode_level(input logic [7:0] code);
    fic_level_t lv;
    case (code)
      `FIC_CODE_LOCKED: lv = FIC_LVL_LOCKED;
      `FIC_CODE_PERM: lv = FIC_LVL_PERM;
      default: lv = FIC_LVL_OPEN;
    endcase
    return lv;
  endfunction

  fic_guard_if gi ();
  fic_guard u_guard (.g(gi.guard));

  logic take;
  logic ctrl_hit;
  logic flash_hit;
  logic cmd_wr;
  logic [15:0] cmd_row;
  logic [1:0] cmd_kind;
  int row_i;
  int base_i;
  logic [7:0] chip_byte;
  logic [7:0] prot_byte;
  logic [31:0] rd_val;

  assign take = i_hsel & i_htrans[1] & i_hready;
  assign ctrl_hit = i_haddr[31:8] == `FIC_CTRL_BASE >> 8;
  assign flash_hit = i_haddr < 32'(FLASH_BYTES); // [RULE_04]
  assign cmd_wr = dp_wr_r && dp_off_r == `FIC_ROW_CMD;
  assign cmd_row = i_hwdata[`FIC_CMD_ROW_LSB +: `FIC_CMD_ROW_W];
  assign cmd_kind = i_hwdata[`FIC_CMD_KIND_LSB +: 2];
  // a process, not an assign, so array writes wake the lookup
  always_comb begin
    chip_byte = mem_byte(USER_ROWS, int'(CPB_OFFSET)); // [RULE_06]
  end

  // row decode for the guard; bounds keep lookups inside the array
  always_comb begin
    row_i = int'(cmd_row);
    gi.kind = fic_kind_t'(cmd_kind);
    gi.level = o_level;
    gi.ext = dp_ext_r;
    gi.prot_bit = 1'b0;
    gi.row_ok = 1'b0;
    prot_byte = 8'h00;
    base_i = 0;
    case (cmd_kind)
      FIC_ROW_USER: begin
        gi.row_ok = row_i < USER_ROWS;
        base_i = row_i;
        if (gi.row_ok) begin
          prot_byte = mem_byte(USER_ROWS + row_i / ROWS_PER_MACRO,
            (row_i % ROWS_PER_MACRO) / 8);
          gi.prot_bit = prot_byte[row_i % 8]; // [RULE_01]
        end
      end
      FIC_ROW_SUPER: begin
        gi.row_ok = row_i < MACROS; // [RULE_13]
        base_i = USER_ROWS + row_i;
      end
      FIC_ROW_USF: begin
        gi.row_ok = row_i < USF_ROWS; // [RULE_07]
        base_i = USER_ROWS + MACROS + row_i;
      end
      default: begin
        gi.row_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_val = `FIC_WORD_RST;
    if (flash_hit) begin
      if (!(o_level == FIC_LVL_LOCKED && i_ext_access)) begin
        rd_val = mem_r[i_haddr[IW+1:2]]; // [RULE_04] [RULE_01] [RULE_05]
      end
    end else if (ctrl_hit) begin
      case (i_haddr[7:0])
        `FIC_BUF_IDX: rd_val = 32'(buf_idx_r);
        `FIC_STATUS: begin
          rd_val[`FIC_ST_BUSY] = state_r == FIC_ST_PROG;
          rd_val[`FIC_ST_REFUSED] = refused_r;
          rd_val[`FIC_ST_LVL_LSB +: 2] = o_level;
          rd_val[`FIC_ST_DONE] = done_r;
        end
        `FIC_CHIP_PROT: rd_val = {24'h00_0000, chip_byte};
        `FIC_GEOM: rd_val = {16'(PROT_BYTES), 16'(ROW_BYTES)}; // [RULE_02]
        default: rd_val = `FIC_WORD_RST;
      endcase
    end
  end

  // zero-wait slave: read data is captured at the address phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= `FIC_WORD_RST;
      dp_wr_r <= 1'b0;
      dp_ext_r <= 1'b0;
      dp_off_r <= 8'h00;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (take && !i_hwrite) begin
        o_hrdata <= rd_val;
      end
      if (i_hready) begin
        dp_wr_r <= take & i_hwrite & ctrl_hit;
        dp_ext_r <= i_ext_access;
        dp_off_r <= i_haddr[7:0];
      end
    end
  end

  // row buffer loads are ignored while a row is being committed
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      buf_idx_r <= '0;
    end else if (dp_wr_r && state_r == FIC_ST_IDLE) begin
      if (dp_off_r == `FIC_BUF_IDX) begin
        buf_idx_r <= i_hwdata[BW-1:0];
      end else if (dp_off_r == `FIC_BUF_DATA) begin
        buf_r[buf_idx_r] <= i_hwdata;
        buf_idx_r <= buf_idx_r + 1'b1;
      end
    end
  end

  // one command commits one whole row from the buffer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= FIC_ST_IDLE;
      cnt_r <= '0;
      prog_base_r <= '0;
      refused_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      case (state_r)
        FIC_ST_IDLE: begin
          if (cmd_wr) begin
            refused_r <= !gi.allow; // [RULE_01] [RULE_05]
            done_r <= 1'b0;
            cnt_r <= '0;
            prog_base_r <= IW'(base_i * WPR);
            if (gi.allow) begin
              state_r <= FIC_ST_PROG; // [RULE_03]
            end
          end
        end
        FIC_ST_PROG: begin
          if (cmd_wr) begin
            refused_r <= 1'b1;
          end
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == BW'(WPR - 1)) begin
            state_r <= FIC_ST_IDLE;
            done_r <= 1'b1;
          end
        end
        default: begin
          state_r <= FIC_ST_IDLE;
        end
      endcase
    end
  end

  // cleared at reset so simulation starts defined; a real array keeps it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < TOT_W; i++) begin
        mem_r[i] <= `FIC_WORD_RST;
      end
    end else if (state_r == FIC_ST_PROG) begin
      mem_r[prog_base_r + IW'(cnt_r)] <= buf_r[cnt_r]; // [RULE_13]
    end
  end

  // level follows the stored byte; permanent keeps debug off until reset clears the array
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= FIC_LVL_OPEN;
      o_dbg_port_en <= 1'b1;
      o_busy <= 1'b0;
    end else begin
      o_level <= decode_level(chip_byte); // [RULE_05] [RULE_06]
      o_dbg_port_en <= decode_level(chip_byte) != FIC_LVL_PERM; // [RULE_05]
      o_busy <= (state_r == FIC_ST_PROG && cnt_r != BW'(WPR - 1)) ||
        (state_r == FIC_ST_IDLE && cmd_wr && gi.allow);
    end
  end
endmodule

// ==== fic_flash_ctl_properties.sv ====
module fic_chk #(
  parameter int ROW_BYTES = 128
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_ext_access,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_busy,
  input wire logic o_dbg_port_en,
  input wire fic_pkg::fic_level_t o_level
);
  import fic_pkg::*;
  int busy_n;
  logic rd_take;
  assign rd_take = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  always_ff @(posedge i_clk) begin
    busy_n <= (i_rst || !o_busy) ? 0 : busy_n + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_ready_high: assert property (o_hreadyout) else $error("not ready");
  a_resp_okay: assert property (!o_hresp) else $error("bad resp");
  a_dbg_kill: assert property (
    o_dbg_port_en == (o_level != FIC_LVL_PERM)) else $error("dbg en");
  a_busy_len: assert property (
    $fell(o_busy) |-> busy_n == ROW_BYTES / 4) else $error("busy len");
  a_rdata_hold: assert property (
    !rd_take |=> $stable(o_hrdata)) else $error("rdata moved");
  a_locked_read: assert property (
    rd_take && i_ext_access && i_haddr < 32'h0001_0000 &&
    o_level == FIC_LVL_LOCKED |=> o_hrdata == 32'h0000_0000)
    else $error("locked read");
  a_perm_still: assert property (
    o_level == FIC_LVL_PERM |=> !$rose(o_busy)) else $error("perm busy");
  a_reset_state: assert property (disable iff (1'b0)
    i_rst |=> o_level == FIC_LVL_OPEN && o_dbg_port_en && !o_busy)
    else $error("reset state");
  c_row_done: cover property ($fell(o_busy));
  c_locked: cover property (o_level == FIC_LVL_LOCKED);
  c_perm: cover property (o_level == FIC_LVL_PERM);
endmodule

bind fic_flash_ctl fic_chk #(.ROW_BYTES(ROW_BYTES)) fic_chk_i (.*);

// ==== fic_prog.sv ====
module fic_prog (
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [31:0] o_hwdata,
  output logic o_ext
);
  timeunit 1ns;
  timeprecision 1ns;
  int tmo = 0;
  // image sections the programmer maps
  localparam logic [31:0] IMG_CSUM = 32'h9030_0000;
  localparam logic [31:0] IMG_PROT = 32'h9040_0000;
  localparam logic [31:0] IMG_META = 32'h9050_0000;
  localparam logic [31:0] IMG_CHIP = 32'h9060_0000;
  // flags hold until the next check rewrites them; meta_check also clears sum_bad
  logic id_bad = 1'h0;
  logic ver_bad = 1'h0;
  logic sum_bad = 1'h0;
  function automatic int prot_len(input int flash, input int rbytes);
    return flash / rbytes / 8;
  endfunction
  // internal and reserved bytes never looked at
  task automatic meta_check(input logic [95:0] m, input logic [31:0] id);
    ver_bad = m[95:80] != 16'h0002;
    id_bad = m[79:72] != id[31:24] || m[71:64] != id[23:16] ||
      m[55:48] != id[7:0];
    sum_bad = 1'h0;
  endtask
  // whole rows of the target summed, low two bytes kept
  task automatic sum_check(input int first, input int rows,
                           input logic [15:0] img);
    logic [31:0] q;
    logic [15:0] s;
    s = 16'h0000;
    for (int a = first * 32; a < (first + rows) * 32; a++) begin
      xfer(1'h0, 32'(4 * a), 32'h0000_0000, q);
      s = s + 16'(q[7:0]) + 16'(q[15:8]) + 16'(q[23:16]) +
        16'(q[31:24]);
    end
    sum_bad = s != img;
  endtask
  initial begin
    o_hsel = 1'h0;
    o_haddr = 32'h0000_0000;
    o_htrans = 2'h0;
    o_hwrite = 1'h0;
    o_hwdata = 32'h0000_0000;
    o_ext = 1'h0;
  end
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge i_clk);
    while (!i_hready && n < 64) begin
      n++;
      @(posedge i_clk);
    end
    if (!i_hready) tmo++;
  endtask
  task automatic set_ext(input logic v);
    o_ext <= v;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    o_hsel <= 1'h1;
    o_haddr <= a;
    o_htrans <= 2'h2;
    o_hwrite <= w;
    wait_rdy();
    o_hsel <= 1'h0;
    o_htrans <= 2'h0;
    o_hwdata <= d;
    wait_rdy();
    q = i_hrdata;
  endtask
  // kind 1 lands protection data in a supervisory row
  task automatic prog_row(input logic [1:0] k, input logic [15:0] r,
                          input logic [31:0] b, input logic [31:0] w31);
    logic [31:0] q;
    xfer(1'h1, 32'h4000_0000, 32'h0000_0000, q);
    for (int i = 0; i < 32; i++) begin
      xfer(1'h1, 32'h4000_0004, i == 31 ? w31 : b + i, q);
    end
    xfer(1'h1, 32'h4000_0008, {14'h0000, k, r}, q);
  endtask
endmodule

// ==== tb_fic_flash_ctl.sv ====
module tb_fic_flash_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  import fic_pkg::*;
  localparam logic [31:0] ST = 32'h4000_000C;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic hsel, hwrite, ext, hrdy, hresp, busy, dbg;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  fic_level_t level;
  int failures = 0;
  int checks = 0;
  initial forever #10 i_clk = ~i_clk;
  fic_flash_ctl fic_flash_ctl_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .i_ext_access(ext),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .o_busy(busy),
    .o_dbg_port_en(dbg), .o_level(level));
  fic_prog fic_prog_i (.i_clk(i_clk), .i_hready(hrdy), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hwdata(hwdata), .o_ext(ext));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    fic_prog_i.xfer(1'h0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // leaves the settled status word in q
  task automatic row(input logic [1:0] k, input logic [15:0] r,
                     input logic [31:0] b, input logic [31:0] w);
    int n;
    fic_prog_i.prog_row(k, r, b, w);
    n = 0;
    do begin
      fic_prog_i.xfer(1'h0, ST, 32'h0000_0000, q);
      n++;
    end while (q[0] && n < 60);
    chk(q & 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic report_and_stop();
    failures += fic_prog_i.tmo;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'h0;
    rd(32'h4000_0014, 32'h0020_0080);
    rd(ST, 32'h0000_0000);
    rd(32'h4000_0020, 32'h0000_0000);
    $display("test reset finished");
    row(2'h0, 16'h0003, 32'h0300_0000, 32'h0300_001F);
    chk(q, 32'h0000_0010);
    for (int i = 0; i < 32; i++) begin
      rd(32'h0000_0180 + 32'(4 * i), 32'h0300_0000 + i);
    end
    row(2'h1, 16'h0000, 32'h0000_0008, 32'h0000_0000);
    chk(q, 32'h0000_0010);
    row(2'h0, 16'h0003, 32'h0A00_0000, 32'h0A00_0000);
    chk(q, 32'h0000_0002);
    rd(32'h0000_0180, 32'h0300_0000);
    row(2'h0, 16'h0002, 32'h0200_0000, 32'h0200_001F);
    chk(q, 32'h0000_0010);
    row(2'h2, 16'h0004, 32'h0000_0000, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    row(2'h2, 16'h0003, 32'h0000_0000, 32'h0000_0000);
    chk(q, 32'h0000_0010);
    $display("test rows finished");
    row(2'h1, 16'h0000, 32'h0000_0008, 32'h0200_0000);
    rd(32'h4000_0010, 32'h0000_0002);
    rd(ST, 32'h0000_0014);
    fic_prog_i.set_ext(1'h1);
    rd(32'h0000_0100, 32'h0000_0000);
    row(2'h0, 16'h0005, 32'h0000_0000, 32'h0000_0000);
    chk(q, 32'h0000_0006);
    fic_prog_i.set_ext(1'h0);
    rd(32'h0000_0100, 32'h0200_0000);
    $display("test locked finished");
    row(2'h1, 16'h0000, 32'h0000_0008, 32'h0400_0000);
    rd(ST, 32'h0000_0018);
    chk({31'h0000_0000, dbg}, 32'h0000_0000);
    row(2'h0, 16'h0006, 32'h0000_0000, 32'h0000_0000);
    chk(q, 32'h0000_000A);
    $display("test permanent finished");
    chk(32'(fic_prog_i.prot_len(65536, 128)), 32'h0000_0040);
    fic_prog_i.sum_check(2, 2, 16'h0480);
    chk(32'(fic_prog_i.sum_bad), 32'h0000_0000);
    fic_prog_i.sum_check(2, 2, 16'h0481);
    chk(32'(fic_prog_i.sum_bad), 32'h0000_0001);
    fic_prog_i.meta_check(96'h0002_1234_0156_FFFF_AAAA_AAAA,
      32'h1234_0956);
    chk({30'h0000_0000, fic_prog_i.id_bad, fic_prog_i.ver_bad},
      32'h0000_0000);
    chk(32'(fic_prog_i.sum_bad), 32'h0000_0000);
    fic_prog_i.meta_check(96'h0002_1234_0156_FFFF_AAAA_AAAA,
      32'h1234_0157);
    chk({30'h0000_0000, fic_prog_i.id_bad, fic_prog_i.ver_bad},
      32'h0000_0002);
    fic_prog_i.meta_check(96'h0003_1234_0156_0000_0000_0000,
      32'h1234_0056);
    chk({30'h0000_0000, fic_prog_i.id_bad, fic_prog_i.ver_bad},
      32'h0000_0001);
    $display("test image finished");
    report_and_stop();
  end
endmodule
